// [logic/apir_irq.sv]
// apir_irq: sticky event status, mask and one level interrupt.
// assumes events are one-cycle pulses and the clear and mask writes
// are one-cycle strobes from the register decoder.
`timescale 1ns/10ps

module apir_irq (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events and register writes
  input wire logic [2:0] event_in,
  input wire logic wr_stat,
  input wire logic wr_mask,
  input wire logic [2:0] wdata,
  // state seen by software and the system
  output logic [2:0] stat,
  output logic [2:0] mask,
  output logic irq
);
  import apir_pkg::*;

  apir_irq_s st;
  apir_irq_s next_st;

  // ****************************************************************
  // next state
  // ****************************************************************
  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    next_st = st;
    if (wr_stat) begin
      next_st.stat = st.stat & ~wdata;
    end
    next_st.stat = next_st.stat | event_in;
    if (wr_mask) begin
      next_st.mask = wdata;
    end
    next_st.irq = |(next_st.stat & next_st.mask);
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '{stat: IRQ_RST, mask: IRQ_RST, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign stat = st.stat;
  assign mask = st.mask;
  assign irq = st.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    irq == |(stat & mask))
    else $error("interrupt level does not follow status and mask");

  a_set_wins: assert property (@(posedge clock) disable iff (rst)
    (event_in != 3'h0) |=> ((stat & $past(event_in)) == $past(event_in)))
    else $error("event lost in status register");

endmodule

// [logic/apir_route.sv]
// apir_route: per-program interrupt routing for triggered conversion
// programs, with its register port and event interrupt.
// assumes the converter gives a one-cycle start strobe with the
// program number, and the bus master never strobes read and write
// together.
//
// Notes on behaviour
// - six routing registers, index 0 to 5, one per program.
// - code 01 sends the program's interrupt to a, 10 to b.
// - codes 00 and 11 give no interrupt on either output.
// - only the register of the started program picks the output.
// - program numbers 000 to 101 are programs 0 to 5; 110, 111 reserved.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps

module apir_route (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire apir_pkg::apir_bus_s bus,
  output logic [31:0] rdata,
  // program start from the converter
  input wire apir_pkg::apir_start_s start,
  // routed program interrupts, one-cycle pulses
  output logic program_irq_a,
  output logic program_irq_b,
  // event interrupt, level
  output logic irq
);
  import apir_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // true when a program number names a real program
  function automatic logic prog_ok(input logic [2:0] num);
    prog_ok = (num <= PROG_LAST);
  endfunction

  // route code to {b, a}; both codes other than a and b are silent
  function automatic logic [1:0] route_dest(input logic [1:0] code);
    unique case (code)
      ROUTE_A: route_dest = 2'h1;
      ROUTE_B: route_dest = 2'h2;
      default: route_dest = 2'h0;
    endcase
  endfunction

  // true when an address hits one of the routing registers
  function automatic logic is_route(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - OFF_ROUTE0;
    is_route = (addr >= OFF_ROUTE0) && (rel[1:0] == 2'h0) &&
               (rel[7:2] < 6'(NUM_PROG));
  endfunction

  // routing register index of an address
  function automatic logic [2:0] route_idx(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - OFF_ROUTE0;
    route_idx = rel[4:2];
  endfunction

  // ****************************************************************
  // state and wiring
  // ****************************************************************
  apir_state_s st;
  apir_state_s next_st;
  logic [2:0] ev;
  logic [1:0] dest;
  logic [1:0] cur_code;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic wr_stat;
  logic wr_mask;

  // code of the started program; reserved numbers read as silent
  // the index is formed only for real numbers, as a reserved one
  // would reach past the sixth register
  always_comb begin
    cur_code = ROUTE_NONE;
    if (prog_ok(start.num)) begin
      cur_code = st.route[start.num];
    end
  end

  // decode of the start strobe into the two routes
  always_comb begin
    dest = 2'h0;
    if (start.start && prog_ok(start.num)) begin
      dest = route_dest(cur_code);
    end
  end

  // events reported to the interrupt block
  // reserved numbers are still reported, so software learns of a
  // trigger that points at no program
  always_comb begin
    ev = 3'h0;
    ev[EV_A] = dest[0];
    ev[EV_B] = dest[1];
    ev[EV_BAD] = start.start && !prog_ok(start.num);
  end

  // interrupt register strobes
  assign wr_stat = bus.wr && (bus.addr == OFF_IRQ_STAT);
  assign wr_mask = bus.wr && (bus.addr == OFF_IRQ_MASK);

  // ****************************************************************
  // next state
  // ****************************************************************
  // a write and a start in one cycle: the start uses the old code,
  // so the new route applies from the next start onward
  always_comb begin
    next_st = st;
    next_st.pulse_a = dest[0];
    next_st.pulse_b = dest[1];
    // read data fall back to zero every cycle, so a stale word is
    // never taken for a fresh answer
    next_st.rdata = 32'h0;
    // register writes; only the two field bits are kept
    if (bus.wr && is_route(bus.addr)) begin
      next_st.route[route_idx(bus.addr)] =
        bus.wdata[ROUTE_LSB +: ROUTE_W];
    end
    // register reads, answered in the next cycle only
    if (bus.rd) begin
      if (is_route(bus.addr)) begin
        next_st.rdata = {30'h0, st.route[route_idx(bus.addr)]};
      end else if (bus.addr == OFF_IRQ_STAT) begin
        next_st.rdata = {29'h0, irq_stat};
      end else if (bus.addr == OFF_IRQ_MASK) begin
        next_st.rdata = {29'h0, irq_mask};
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset clears every route so no interrupt leaves before setup
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '{route: {6{ROUTE_RST}}, pulse_a: 1'b0, pulse_b: 1'b0,
              rdata: 32'h0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign program_irq_a = st.pulse_a;
  assign program_irq_b = st.pulse_b;

  // ****************************************************************
  // event interrupt
  // ****************************************************************
  apir_irq u_irq (
    .clock(clock),
    .rst(rst),
    .event_in(ev),
    .wr_stat(wr_stat),
    .wr_mask(wr_mask),
    .wdata(bus.wdata[2:0]),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(irq)
  );

  // ****************************************************************
  // checks: routing of program starts
  // ****************************************************************
  // the started program's code picks a; only a pulses
  a_route_to_a: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && prog_ok(start.num) && cur_code == ROUTE_A)
    |=> (program_irq_a && !program_irq_b))
    else $error("program routed to a did not pulse a only");

  // the same for b
  a_route_to_b: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && prog_ok(start.num) && cur_code == ROUTE_B)
    |=> (program_irq_b && !program_irq_a))
    else $error("program routed to b did not pulse b only");

  // one start has one destination, so a and b never pulse together
  a_pulse_exclusive: assert property (
    @(posedge clock) disable iff (rst)
    !(program_irq_a && program_irq_b))
    else $error("both routed interrupts raised in one cycle");

  // a routed start is also recorded in the status for software
  a_status_a_set: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && prog_ok(start.num) && cur_code == ROUTE_A)
    |=> irq_stat[EV_A])
    else $error("start routed to a not recorded in status");

  // and the same for b
  a_status_b_set: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && prog_ok(start.num) && cur_code == ROUTE_B)
    |=> irq_stat[EV_B])
    else $error("start routed to b not recorded in status");

  // both unused codes are silent on the outputs
  a_route_silent: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && (cur_code == ROUTE_NONE || cur_code == ROUTE_OFF))
    |=> (!program_irq_a && !program_irq_b))
    else $error("silent route code raised an interrupt");

  // and in the status: a silent start must not look like a routed one
  a_silent_no_event: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && prog_ok(start.num) && !bus.wr &&
     (cur_code == ROUTE_NONE || cur_code == ROUTE_OFF))
    |=> (irq_stat[EV_B:EV_A] == $past(irq_stat[EV_B:EV_A])))
    else $error("silent route code set a routing status bit");

  // pulses only ever follow a start
  a_no_start_quiet: assert property (
    @(posedge clock) disable iff (rst)
    !start.start |=> (!program_irq_a && !program_irq_b))
    else $error("interrupt pulse without a program start");

  // the code one cycle back in the started program's own register
  // decides; the other five registers play no part
  a_own_register: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && prog_ok(start.num))
    |=> (program_irq_a == ($past(st.route[start.num]) == ROUTE_A) &&
         program_irq_b == ($past(st.route[start.num]) == ROUTE_B)))
    else $error("pulse does not follow the started program's code");

  // reserved numbers: no pulse, the reserved status bit instead
  a_reserved_prog: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && start.num > PROG_LAST)
    |=> (!program_irq_a && !program_irq_b && irq_stat[EV_BAD]))
    else $error("reserved program number not handled");

  // a real number never raises the reserved status bit
  a_real_prog_ok: assert property (
    @(posedge clock) disable iff (rst)
    (start.start && prog_ok(start.num) && !irq_stat[EV_BAD])
    |=> !irq_stat[EV_BAD])
    else $error("real program number flagged as reserved");

  // ****************************************************************
  // checks: register port
  // ****************************************************************
  // reset leaves every route silent and both outputs low
  a_reset_routes: assert property (
    @(posedge clock)
    rst |=> (st.route == '0 && !program_irq_a && !program_irq_b))
    else $error("routes not cleared by reset");

  // a route write followed at once by a read of it returns the field
  a_write_read: assert property (
    @(posedge clock) disable iff (rst)
    (bus.wr && is_route(bus.addr)) ##1
    (bus.rd && bus.addr == $past(bus.addr) && !start.start)
    |=> (rdata == {30'h0, $past(bus.wdata[1:0], 2)}))
    else $error("routing field read back wrong");

  // a route write lands in its own field; the upper bits are dropped
  a_write_lands: assert property (
    @(posedge clock) disable iff (rst)
    (bus.wr && is_route(bus.addr))
    |=> (st.route[$past(route_idx(bus.addr))] == $past(bus.wdata[1:0])))
    else $error("route write did not land in its field");

  // writes past the sixth route must not alias onto any route
  a_routes_kept: assert property (
    @(posedge clock) disable iff (rst)
    (bus.wr && bus.addr >= OFF_ROUTE0 + 8'(4 * NUM_PROG))
    |=> $stable(st.route))
    else $error("write past the sixth route changed a route");

  // reads of a route give zero above the two field bits
  a_route_upper_zero: assert property (
    @(posedge clock) disable iff (rst)
    (bus.rd && is_route(bus.addr)) |=> (rdata[31:2] == 30'h0))
    else $error("upper bits of a routing register not zero");

  // read data stand for one cycle only and are zero otherwise
  a_rdata_idle: assert property (
    @(posedge clock) disable iff (rst)
    !bus.rd |=> (rdata == 32'h0))
    else $error("read data present without a read");

  // the word after the sixth route is the status, not a seventh route
  a_six_regs: assert property (
    @(posedge clock) disable iff (rst)
    (bus.rd && bus.addr == OFF_ROUTE0 + 8'h18)
    |=> (rdata == {29'h0, $past(irq_stat)}))
    else $error("address after the sixth route decoded as a route");

  // the mask reads back as it stood at the read
  a_mask_read: assert property (
    @(posedge clock) disable iff (rst)
    (bus.rd && bus.addr == OFF_IRQ_MASK)
    |=> (rdata == {29'h0, $past(irq_mask)}))
    else $error("mask register read back wrong");

endmodule

// [shared/apir_pkg.sv]
// apir_pkg: constants and carriers for the program interrupt router.
// assumes one 20 MHz clock, synchronous active-high reset, byte
// addresses on a plain register port with 32-bit data.

package apir_pkg;

  // ****************************************************************
  // programs and route codes
  // ****************************************************************
  localparam int unsigned NUM_PROG = 6;
  localparam logic [2:0] PROG_LAST = 3'h5; // 3'h6, 3'h7 reserved
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_A = 2'h1;
  localparam logic [1:0] ROUTE_B = 2'h2;
  localparam logic [1:0] ROUTE_OFF = 2'h3;
  localparam logic [1:0] ROUTE_RST = 2'h0;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_ROUTE0 = 8'h00; // route n at +4*n
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  localparam int unsigned ROUTE_LSB = 0;
  localparam int unsigned ROUTE_W = 2;

  // ****************************************************************
  // interrupt status bits
  // ****************************************************************
  localparam int unsigned EV_A = 0;   // program started, sent to a
  localparam int unsigned EV_B = 1;   // program started, sent to b
  localparam int unsigned EV_BAD = 2; // start with reserved number
  localparam int unsigned IRQ_W = 3;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ****************************************************************
  // carriers and state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } apir_bus_s;

  typedef struct packed {
    logic start;
    logic [2:0] num;
  } apir_start_s;

  typedef struct packed {
    logic [5:0][1:0] route;
    logic pulse_a;
    logic pulse_b;
    logic [31:0] rdata;
  } apir_state_s;

  typedef struct packed {
    logic [2:0] stat;
    logic [2:0] mask;
    logic irq;
  } apir_irq_s;

endpackage

// [tb/apir_route_tb_top.sv]
// apir_route_tb_top: self-checking bench for the program interrupt router.
// assumes the register map, status layout and pulse timing of apir_pkg.
`timescale 1ns/10ps

module apir_route_tb_top;
  import apir_pkg::*;

  // ****************************************************************
  // stimulus, design and reference model
  // ****************************************************************
  logic clock = 1'b0;
  logic rst = 1'b1;
  apir_bus_s bus = '0;
  apir_start_s start = '0;
  logic [31:0] rdata;
  logic program_irq_a;
  logic program_irq_b;
  logic irq;
  int bad_count = 0;
  int cmp_count = 0;
  int m_route [NUM_PROG] = '{default: 0};
  int m_stat = 0;
  int m_mask = 0;

  // 50 ns period
  always #25 clock = ~clock;

  apir_route apir_route_i (
    .clock(clock),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .start(start),
    .program_irq_a(program_irq_a),
    .program_irq_b(program_irq_b),
    .irq(irq)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // model value of a register; unmapped places read zero
  function automatic int exp_of(int a);
    if (a <= 'h14) return m_route[a / 4];
    if (a == 'h18) return m_stat;
    if (a == 'h1c) return m_mask;
    return 0;
  endfunction

  // one-cycle write; the model follows at the same edge
  task automatic wr(int a, logic [31:0] d);
    @(posedge clock);
    bus.addr <= 8'(a);
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    if (a <= 'h14) m_route[a / 4] = int'(d & 32'h3);
    else if (a == 'h18) m_stat &= ~int'(d);
    else if (a == 'h1c) m_mask = int'(d & 32'h7);
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rd(int a, output logic [31:0] v);
    @(posedge clock);
    bus.addr <= 8'(a);
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    @(negedge clock);
    v = rdata;
    @(negedge clock);
    chk(rdata, 32'h0);
  endtask

  // route write and read of it with no gap between the strobes
  task automatic wr_rd(int a, logic [31:0] d, output logic [31:0] v);
    @(posedge clock);
    bus.addr <= 8'(a);
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    m_route[a / 4] = int'(d & 32'h3);
    @(posedge clock);
    bus.rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask

  // start a program and compare routed pulses and level interrupt
  task automatic go(logic [2:0] n);
    int code;
    @(posedge clock);
    start.start <= 1'b1;
    start.num <= n;
    @(posedge clock);
    start.start <= 1'b0;
    @(negedge clock);
    code = (n <= PROG_LAST) ? m_route[n] : 0;
    if (n > PROG_LAST) m_stat |= 4;
    else if (code == 1) m_stat |= 1;
    else if (code == 2) m_stat |= 2;
    chk(32'(program_irq_a), 32'(code == 1));
    chk(32'(program_irq_b), 32'(code == 2));
    chk(32'(irq), 32'((m_stat & m_mask) != 0));
    @(negedge clock);
    chk(32'({program_irq_a, program_irq_b}), 32'h0);
  endtask

  // ****************************************************************
  // verdict and watchdog
  // ****************************************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under 2000 cycles
  initial begin
    #(50 * 20000);
    bad_count++;
    wrap_up();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] v;
    logic [31:0] d;
    void'($urandom(32'hafbb));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // every place reads zero straight after reset
    for (int a = 0; a <= 'h24; a += 4) begin
      rd(a, v);
      chk(v, 32'h0);
    end
    // random words: upper bits dropped, unmapped writes lost
    for (int a = 0; a <= 'h24; a += 4) begin
      d = $urandom;
      wr(a, d);
      rd(a, v);
      chk(v, 32'(exp_of(a)));
    end
    // write then read at once, strobes back to back
    for (int n = 0; n < NUM_PROG; n++) begin
      wr_rd(4 * n, $urandom, v);
      chk(v, 32'(exp_of(4 * n)));
    end
    wr('h1c, 32'h7);
    wr('h18, 32'h7);
    // every program with every code; other routes hold stale codes
    for (int n = 0; n < NUM_PROG; n++) begin
      for (int c = 0; c < 4; c++) begin
        wr(4 * n, 32'hfffffffc | 32'(c));
        go(3'(n));
      end
    end
    // random routes and numbers, reserved ones included
    repeat (60) begin
      wr(4 * ($urandom % NUM_PROG), $urandom);
      if ($urandom % 3 == 0) wr('h1c, $urandom);
      go(3'($urandom % 8));
      if ($urandom % 4 == 0) wr('h18, $urandom);
    end
    rd('h18, v);
    chk(v, 32'(m_stat));
    // clear and mask: level must follow at once
    wr('h1c, 32'h7);
    wr('h18, 32'h3);
    go(3'h7);
    wr('h1c, 32'h3);
    @(negedge clock);
    chk(32'(irq), 32'h0);
    wr('h18, 32'h7);
    rd('h18, v);
    chk(v, 32'h0);
    // reset in mid-run: routes, status and mask all back to zero
    wr(0, 32'h1);
    wr('h1c, 32'h7);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    m_route = '{default: 0};
    m_stat = 0;
    m_mask = 0;
    go(3'h0);
    go(3'h7);
    rd(0, v);
    chk(v, 32'h0);
    rd('h18, v);
    chk(v, 32'(m_stat));
    wrap_up();
  end
endmodule
